//--- hdl/irp_pending_regs.sv
`timescale 1ns/1ps
module irp_pending_regs (
   input wire logic clk_i, // system clock, 125 MHz
   input wire logic rst_i, // synchronous reset, active high
   // wishbone classic slave
   input wire logic wb_cyc_i, // bus cycle
   input wire logic wb_stb_i, // strobe
   input wire logic wb_we_i, // write enable
   input wire logic [25:0] wb_adr_i, // byte address
   input wire logic [3:0] wb_sel_i, // byte lane selects
   input wire logic [31:0] wb_dat_i, // write data
   output logic [31:0] wb_dat_o, // read data
   output logic wb_ack_o, // cycle acknowledge
   // group 0 sources, one-cycle pulses
   input wire logic timer2_request_i, // timer 2
   input wire logic timer1_request_i, // timer 1
   input wire logic timer0_request_i, // timer 0
   input wire logic uart0_receive_request_i, // uart 0 receive
   input wire logic uart0_transmit_request_i, // uart 0 transmit
   input wire logic i2c_request_i, // i2c
   input wire logic spi_request_i, // spi
   input wire logic adc_request_i, // adc
   // group 1 sources, toggling levels
   input wire logic [7:0] port_pin_request_i, // port a/d pins
   input wire logic comparator_mux_request_i, // comparator level
   input wire logic debugger_mux_request_i, // on-chip debugger level
   // group 2 sources, one-cycle pulses
   input wire logic [7:0] group2_request_i, // group 2 sources
   // processor core side
   input wire logic core_ack_i, // acknowledge pulse
   input wire logic [1:0] core_ack_group_i, // acknowledged group
   input wire logic [2:0] core_ack_bit_i, // acknowledged bit
   output logic core_req_o, // vectored request level
   output logic [7:0] pending_group0_o, // group 0 pending bits
   output logic [7:0] pending_group1_o, // group 1 pending bits
   output logic [7:0] pending_group2_o, // group 2 pending bits
   output logic irq_o // unmasked event interrupt
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic [7:0] pend0; // group 0 pending
      logic [7:0] pend1; // group 1 pending
      logic [7:0] pend2; // group 2 pending
      // prev1 resets low, so a pin that sits high at release
      // is counted once as a toggle on the first edge
      logic [7:0] prev1; // last selected group 1 levels
      logic [2:0] ctrl; // control bits
      logic [2:0] evt; // sticky event status
      logic [2:0] mask; // event mask
      logic ack; // bus acknowledge
      logic [31:0] rdat; // bus read data
      logic req; // core request
      logic irq; // interrupt line
   } irp_state_t;

   irp_state_t st_q; // registered state
   irp_state_t st_d; // next state

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // register hit on the word index
   // the two low address bits are ignored, registers sit on word bounds
   function automatic logic hit(input logic [25:0] adr, input logic [23:0] idx);
      hit = (adr[25:2] == idx);
   endfunction : hit

   // pending update, set wins over clear
   function automatic logic [7:0] upd(input logic [7:0] cur, input logic [7:0] set_v,
                                      input logic [7:0] clr_v);
      upd = (cur & ~clr_v) | set_v;
   endfunction : upd

   // one-hot acknowledge for one group
   // group code 3 matches no group and is ignored
   function automatic logic [7:0] ack_vec(input logic ack, input logic [1:0] grp,
                                          input logic [1:0] want, input logic [2:0] bitn);
      ack_vec = (ack && grp == want) ? (8'h01 << bitn) : 8'h00;
   endfunction : ack_vec

   // ----------------------------------------
   // combinational temporaries
   // ----------------------------------------
   logic wr_en; // write takes effect this edge
   logic rd_en; // read data captured this edge
   logic [7:0] wbyte; // low write byte, lane 0 gated
   logic [7:0] hw0; // group 0 hardware sets
   logic [7:0] sel1; // selected group 1 levels
   logic [7:0] hw1; // group 1 hardware sets
   logic [7:0] sw_set0; // group 0 software sets
   logic [7:0] sw_set1; // group 1 software sets
   logic [7:0] sw_set2; // group 2 software sets
   logic [7:0] clr0; // group 0 clears
   logic [7:0] clr1; // group 1 clears
   logic [7:0] clr2; // group 2 clears
   logic [2:0] evt_set; // event sets
   logic [2:0] evt_clr; // event clears

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      st_d = st_q;
      // a read is captured on the request edge so read data stands with ack
      // write acts on the edge where the master sees ack
      wr_en = wb_cyc_i && wb_stb_i && wb_we_i && st_q.ack;
      rd_en = wb_cyc_i && wb_stb_i && !st_q.ack;
      wbyte = wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00;

      hw0 = {timer2_request_i, timer1_request_i, timer0_request_i, uart0_receive_request_i,
             uart0_transmit_request_i, i2c_request_i, spi_request_i, adc_request_i};

      sel1 = port_pin_request_i;
      if (st_q.ctrl[irp_pkg::CTRL_CMP_SEL]) begin
         sel1[irp_pkg::PIN_CMP] = comparator_mux_request_i;
      end
      if (st_q.ctrl[irp_pkg::CTRL_DBG_SEL]) begin
         sel1[irp_pkg::PIN_DBG] = debugger_mux_request_i;
      end
      // switching a select can look like a toggle and set the bit
      // toggle sets bit
      hw1 = sel1 ^ st_q.prev1;
      st_d.prev1 = sel1;

      sw_set0 = (wr_en && hit(wb_adr_i, irp_pkg::IDX_SET0)) ? wbyte : 8'h00;
      sw_set1 = (wr_en && hit(wb_adr_i, irp_pkg::IDX_SET1)) ? wbyte : 8'h00;
      sw_set2 = (wr_en && hit(wb_adr_i, irp_pkg::IDX_SET2)) ? wbyte : 8'h00;

      clr0 = ((wr_en && hit(wb_adr_i, irp_pkg::IDX_PEND0)) ? wbyte : 8'h00)
             | ack_vec(core_ack_i, core_ack_group_i, 2'h0, core_ack_bit_i);
      clr1 = ((wr_en && hit(wb_adr_i, irp_pkg::IDX_PEND1)) ? wbyte : 8'h00)
             | ack_vec(core_ack_i, core_ack_group_i, 2'h1, core_ack_bit_i);
      clr2 = ((wr_en && hit(wb_adr_i, irp_pkg::IDX_PEND2)) ? wbyte : 8'h00)
             | ack_vec(core_ack_i, core_ack_group_i, 2'h2, core_ack_bit_i);

      // a pulse that meets a clear still lands; only the clear is lost
      // one pulse, one latch
      st_d.pend0 = upd(st_q.pend0, hw0 | sw_set0, clr0);
      st_d.pend1 = upd(st_q.pend1, hw1 | sw_set1, clr1);
      st_d.pend2 = upd(st_q.pend2, group2_request_i | sw_set2, clr2);

      // sticky events per group, set wins
      evt_set = {|group2_request_i, |hw1, |hw0};
      evt_clr = (wr_en && hit(wb_adr_i, irp_pkg::IDX_EVT)) ? wbyte[2:0] : 3'h0;
      st_d.evt = (st_q.evt & ~evt_clr) | evt_set;

      // control and mask writes
      if (wr_en && hit(wb_adr_i, irp_pkg::IDX_CTRL)) begin
         st_d.ctrl = wbyte[2:0];
      end
      if (wr_en && hit(wb_adr_i, irp_pkg::IDX_MASK)) begin
         st_d.mask = wbyte[2:0];
      end

      // the core request lags the pending bits by one cycle
      // forward when enabled
      st_d.req = st_q.ctrl[irp_pkg::CTRL_GIE] && (|{st_q.pend0, st_q.pend1, st_q.pend2});
      st_d.irq = |(st_q.evt & st_q.mask);

      // ack never stands two cycles, so a master that drops cyc
      // right after the ack edge is never answered twice
      // bus acknowledge, one cycle, then dropped
      st_d.ack = wb_cyc_i && wb_stb_i && !st_q.ack;

      // read mux, set registers and unmapped read zero
      if (rd_en) begin
         st_d.rdat = 32'h00000000;
         if (hit(wb_adr_i, irp_pkg::IDX_PEND0)) begin
            st_d.rdat[7:0] = st_q.pend0;
         end else if (hit(wb_adr_i, irp_pkg::IDX_PEND1)) begin
            st_d.rdat[7:0] = st_q.pend1;
         end else if (hit(wb_adr_i, irp_pkg::IDX_PEND2)) begin
            st_d.rdat[7:0] = st_q.pend2;
         end else if (hit(wb_adr_i, irp_pkg::IDX_CTRL)) begin
            st_d.rdat[2:0] = st_q.ctrl;
         end else if (hit(wb_adr_i, irp_pkg::IDX_EVT)) begin
            st_d.rdat[2:0] = st_q.evt;
         end else if (hit(wb_adr_i, irp_pkg::IDX_MASK)) begin
            st_d.rdat[2:0] = st_q.mask;
         end else begin
            st_d.rdat = 32'h00000000;
         end
      end
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         // ack, read data and request flops start low too
         st_q <= '0;
         st_q.pend0 <= irp_pkg::RST_PEND;
         st_q.pend1 <= irp_pkg::RST_PEND;
         st_q.pend2 <= irp_pkg::RST_PEND;
         st_q.ctrl <= irp_pkg::RST_CTRL;
         st_q.evt <= irp_pkg::RST_EVT;
         st_q.mask <= irp_pkg::RST_MASK;
      end else begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------
   // outputs, straight from flops
   // ----------------------------------------
   // no logic after the flops, so no output can glitch
   assign wb_dat_o = st_q.rdat;
   assign wb_ack_o = st_q.ack;
   assign core_req_o = st_q.req;
   assign pending_group0_o = st_q.pend0;
   assign pending_group1_o = st_q.pend1;
   assign pending_group2_o = st_q.pend2;
   assign irq_o = st_q.irq;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   // set register raises
   chk_set0_raises: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_en && hit(wb_adr_i, irp_pkg::IDX_SET0))
      |=> ((st_q.pend0 & $past(wbyte)) == $past(wbyte)))
      else $error("group 0 set write did not raise bits");

   chk_w1c_clears: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_en && hit(wb_adr_i, irp_pkg::IDX_PEND0) && hw0 == 8'h00 && !core_ack_i)
      |=> ((st_q.pend0 & $past(wbyte)) == 8'h00))
      else $error("group 0 clear write left bits set");

   chk_src_latch: assert property (@(posedge clk_i) disable iff (rst_i)
      (hw0 != 8'h00) |=> ((st_q.pend0 & $past(hw0)) == $past(hw0)))
      else $error("group 0 source pulse not latched");

   chk_toggle_sets: assert property (@(posedge clk_i) disable iff (rst_i)
      (hw1 != 8'h00) |=> ((st_q.pend1 & $past(hw1)) == $past(hw1)))
      else $error("group 1 toggle not latched");

   chk_fwd_enabled: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_q.ctrl[irp_pkg::CTRL_GIE] && st_q.pend2 != 8'h00) |=> core_req_o)
      else $error("pending request not forwarded");

   chk_polled_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
      !st_q.ctrl[irp_pkg::CTRL_GIE] |=> !core_req_o)
      else $error("request forwarded while disabled");

   chk_ack_clears: assert property (@(posedge clk_i) disable iff (rst_i)
      (core_ack_i && core_ack_group_i == 2'h2 && group2_request_i == 8'h00 && !wr_en)
      |=> !st_q.pend2[$past(core_ack_bit_i)])
      else $error("acknowledged bit not cleared");

   chk_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
      ((hw0 & clr0) != 8'h00) |=> ((st_q.pend0 & $past(hw0 & clr0)) == $past(hw0 & clr0)))
      else $error("clear beat a simultaneous set");

   // ----------------------------------------
   // further checks on all three groups, the interrupt line and the bus
   // ----------------------------------------
   // set register raises
   chk_set1_raises: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_en && hit(wb_adr_i, irp_pkg::IDX_SET1))
      |=> ((st_q.pend1 & $past(wbyte)) == $past(wbyte)))
      else $error("group 1 set write did not raise bits");

   chk_set2_raises: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_en && hit(wb_adr_i, irp_pkg::IDX_SET2))
      |=> ((st_q.pend2 & $past(wbyte)) == $past(wbyte)))
      else $error("group 2 set write did not raise bits");

   chk_w1c_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_en && hit(wb_adr_i, irp_pkg::IDX_PEND0) && hw0 == 8'h00 && !core_ack_i)
      |=> ((st_q.pend0 & ~$past(wbyte)) == ($past(st_q.pend0) & ~$past(wbyte))))
      else $error("group 0 clear write changed bits written zero");

   chk_w1c_group1: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_en && hit(wb_adr_i, irp_pkg::IDX_PEND1) && hw1 == 8'h00 && !core_ack_i)
      |=> ((st_q.pend1 & $past(wbyte)) == 8'h00))
      else $error("group 1 clear write left bits set");

   chk_ack_group0: assert property (@(posedge clk_i) disable iff (rst_i)
      (core_ack_i && core_ack_group_i == 2'h0 && hw0 == 8'h00 && !wr_en)
      |=> !st_q.pend0[$past(core_ack_bit_i)])
      else $error("acknowledged group 0 bit not cleared");

   chk_ack_grp3_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
      (core_ack_i && core_ack_group_i == 2'h3 && hw0 == 8'h00 && !wr_en)
      |=> (st_q.pend0 == $past(st_q.pend0)))
      else $error("acknowledge of group 3 changed group 0");

   chk_fwd_any: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_q.ctrl[irp_pkg::CTRL_GIE] && (st_q.pend0 | st_q.pend1 | st_q.pend2) != 8'h00)
      |=> core_req_o)
      else $error("pending request of some group not forwarded");

   chk_cmp_select: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_q.ctrl[irp_pkg::CTRL_CMP_SEL] && comparator_mux_request_i != st_q.prev1[irp_pkg::PIN_CMP])
      |=> st_q.pend1[irp_pkg::PIN_CMP])
      else $error("comparator toggle not latched");

   chk_dbg_select: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_q.ctrl[irp_pkg::CTRL_DBG_SEL] && debugger_mux_request_i != st_q.prev1[irp_pkg::PIN_DBG])
      |=> st_q.pend1[irp_pkg::PIN_DBG])
      else $error("debugger toggle not latched");

   chk_set_wins_g2: assert property (@(posedge clk_i) disable iff (rst_i)
      ((group2_request_i & clr2) != 8'h00)
      |=> ((st_q.pend2 & $past(group2_request_i & clr2)) == $past(group2_request_i & clr2)))
      else $error("clear beat a simultaneous group 2 set");

   chk_pend_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      ((hw0 | sw_set0 | clr0) == 8'h00) |=> $stable(st_q.pend0))
      else $error("group 0 bits changed with no set or clear");

   // interrupt line follows unmasked events
   chk_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
      1'b1 |=> (irq_o == $past(|(st_q.evt & st_q.mask))))
      else $error("interrupt line does not follow unmasked events");

   // read data upper bits stay zero
   chk_read_upper: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |-> (wb_dat_o[31:8] == 24'h000000))
      else $error("read data upper bits not zero");

   // bus acknowledge lasts one cycle
   chk_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("bus acknowledge held two cycles");

endmodule : irp_pending_regs

//--- hdl/irp_pkg.sv
package irp_pkg;
   // ----------------------------------------
   // register indices (byte address = 4 * index)
   // ----------------------------------------
   localparam logic [23:0] IDX_PEND0 = 24'hFFE030; // pending_group0, write 1 to clear
   localparam logic [23:0] IDX_SET0 = 24'hFFE031; // request_set_group0, write only
   localparam logic [23:0] IDX_PEND1 = 24'hFFE034; // pending_group1, write 1 to clear
   localparam logic [23:0] IDX_SET1 = 24'hFFE035; // request_set_group1, write only
   localparam logic [23:0] IDX_PEND2 = 24'hFFE038; // pending_group2, write 1 to clear
   localparam logic [23:0] IDX_SET2 = 24'hFFE039; // request_set_group2, write only
   localparam logic [23:0] IDX_CTRL = 24'hFFE0F0; // control
   localparam logic [23:0] IDX_EVT = 24'hFFE0F1; // event status, write 1 to clear
   localparam logic [23:0] IDX_MASK = 24'hFFE0F2; // event mask

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int CTRL_GIE = 0; // global interrupt enable
   localparam int CTRL_CMP_SEL = 1; // group 1 bit 7 takes comparator
   localparam int CTRL_DBG_SEL = 2; // group 1 bit 0 takes debugger
   localparam int PIN_CMP = 7; // group 1 bit shared with comparator
   localparam int PIN_DBG = 0; // group 1 bit shared with debugger

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [7:0] RST_PEND = 8'h00; // all pending bits clear
   localparam logic [2:0] RST_CTRL = 3'h0; // disabled, port pins selected
   localparam logic [2:0] RST_EVT = 3'h0; // no events
   localparam logic [2:0] RST_MASK = 3'h0; // all events masked
endpackage : irp_pkg

//--- dv/irp_core_model.sv
`timescale 1ns/1ps
// processor core stand-in: acknowledges a forwarded request when asked
module irp_core_model (
   input wire logic clk_i, // system clock
   input wire logic rst_i, // synchronous reset, active high
   input wire logic req_i, // vectored request from the block
   input wire logic serve_i, // bench asks for one acknowledge
   input wire logic [1:0] grp_i, // group to acknowledge
   input wire logic [2:0] bit_i, // bit to acknowledge
   output logic ack_o, // one-cycle acknowledge pulse
   output logic [1:0] ack_grp_o, // acknowledged group
   output logic [2:0] ack_bit_o // acknowledged bit
);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         ack_grp_o <= 2'h3;
         ack_bit_o <= 3'h7;
      end else begin
         ack_o <= serve_i & req_i & ~ack_o;
         // idle qualifiers wander so a stale value is never trusted
         ack_grp_o <= (serve_i & req_i) ? grp_i : ~ack_grp_o;
         ack_bit_o <= (serve_i & req_i) ? bit_i : ~ack_bit_o;
      end
   end
endmodule : irp_core_model

//--- dv/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic clk_i; // system clock
   logic rst_i = 1'b1; // synchronous reset
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0; // bus request
   logic [25:0] adr = 26'h0; // byte address
   logic [31:0] wdat = 32'h0, rdat, dat; // bus data
   logic ack, req, irq, c_ack; // design outputs, core acknowledge
   logic [7:0] src0 = 8'h00, src2 = 8'h00, pins = 8'h00; // sources
   logic cmp = 1'b0, dbg = 1'b0, serve = 1'b0; // mux sources, core request
   logic [1:0] sgrp = 2'h0, c_grp; // acknowledge group
   logic [2:0] sbit = 3'h0, c_bit; // acknowledge bit
   logic [7:0] p0, p1, p2; // pending bits
   int n_fail = 0, check_count = 0; // counters
   logic [23:0] blank[7] = '{irp_pkg::IDX_PEND0, irp_pkg::IDX_PEND1, irp_pkg::IDX_PEND2,
      irp_pkg::IDX_SET0, irp_pkg::IDX_EVT, irp_pkg::IDX_MASK, 24'hFFE0FF}; // all zero after reset

   irp_pending_regs irp_pending_regs_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat), .wb_ack_o(ack),
      .timer2_request_i(src0[7]), .timer1_request_i(src0[6]), .timer0_request_i(src0[5]),
      .uart0_receive_request_i(src0[4]), .uart0_transmit_request_i(src0[3]), .i2c_request_i(src0[2]),
      .spi_request_i(src0[1]), .adc_request_i(src0[0]), .port_pin_request_i(pins),
      .comparator_mux_request_i(cmp), .debugger_mux_request_i(dbg), .group2_request_i(src2),
      .core_ack_i(c_ack), .core_ack_group_i(c_grp), .core_ack_bit_i(c_bit), .core_req_o(req),
      .pending_group0_o(p0), .pending_group1_o(p1), .pending_group2_o(p2), .irq_o(irq));
   irp_core_model irp_core_model_i (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .serve_i(serve),
      .grp_i(sgrp), .bit_i(sbit), .ack_o(c_ack), .ack_grp_o(c_grp), .ack_bit_o(c_bit));

   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic tally_and_finish();
      $display("checks %0d, mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : tally_and_finish

   // one classic cycle, held until ack is sampled high
   task automatic xfer(input logic w, input logic [23:0] idx, input logic [7:0] d);
      int n;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'h0};
      wdat <= {24'h000000, d};
      for (n = 0; n < 20 && ack !== 1'b1; n++) @(posedge clk_i);
      if (ack !== 1'b1) begin
         n_fail++;
         tally_and_finish();
      end
      rdat = dat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : xfer

   task automatic wr(input logic [23:0] idx, input logic [7:0] d);
      xfer(1'b1, idx, d);
   endtask : wr

   task automatic rd(input logic [23:0] idx, input logic [31:0] exp);
      xfer(1'b0, idx, 8'h00);
      chk(rdat, exp);
   endtask : rd

   task automatic wait_n(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : wait_n

   // sources pulse for exactly one cycle
   task automatic pulse(input logic [7:0] a, input logic [7:0] b);
      @(posedge clk_i);
      src0 <= a;
      src2 <= b;
      @(posedge clk_i);
      src0 <= 8'h00;
      src2 <= 8'h00;
      #1;
   endtask : pulse

   // core acknowledge, optionally meeting a group 2 pulse at the same edge
   task automatic serve_core(input logic [1:0] g, input logic [2:0] b, input logic [7:0] s);
      @(posedge clk_i);
      serve <= 1'b1;
      sgrp <= g;
      sbit <= b;
      @(posedge clk_i);
      serve <= 1'b0;
      src2 <= s;
      @(posedge clk_i);
      src2 <= 8'h00;
      #1;
   endtask : serve_core

   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      wr(24'hFFE0FF, 8'hFF);
      foreach (blank[i]) rd(blank[i], 32'h0);
      $display("reset test done");
      pulse(8'h01, 8'h00);
      rd(irp_pkg::IDX_EVT, 32'h1);
      chk(32'(irq), 32'h0);
      wr(irp_pkg::IDX_MASK, 8'h01);
      wait_n(1);
      chk(32'(irq), 32'h1);
      wr(irp_pkg::IDX_EVT, 8'h01);
      wait_n(1);
      chk(32'(irq), 32'h0);
      wr(irp_pkg::IDX_MASK, 8'h00);
      for (int i = 0; i < 8; i++) begin
         pulse(8'h01 << i, 8'h80 >> i);
         chk(32'(p0), 32'h1 << i);
         chk(32'(p2), 32'h80 >> i);
         wr(irp_pkg::IDX_PEND0, 8'hFF);
         wr(irp_pkg::IDX_PEND2, 8'hFF);
         rd(irp_pkg::IDX_PEND0, 32'h0);
      end
      $display("source test done");
      wr(irp_pkg::IDX_SET0, 8'hA5);
      rd(irp_pkg::IDX_PEND0, 32'hA5);
      rd(irp_pkg::IDX_SET0, 32'h0);
      chk(32'(req), 32'h0);
      wr(irp_pkg::IDX_PEND0, 8'h05);
      rd(irp_pkg::IDX_PEND0, 32'hA0);
      wr(irp_pkg::IDX_CTRL, 8'h01);
      wait_n(2);
      chk(32'(req), 32'h1);
      serve_core(2'h0, 3'h7, 8'h00);
      chk(32'(p0), 32'h20);
      wr(irp_pkg::IDX_PEND0, 8'h20);
      wait_n(2);
      chk(32'(req), 32'h0);
      wr(irp_pkg::IDX_SET2, 8'h02);
      serve_core(2'h2, 3'h1, 8'h02);
      chk(32'(p2), 32'h02);
      serve_core(2'h2, 3'h1, 8'h00);
      chk(32'(p2), 32'h00);
      // source pulse lands on the edge where a clear write takes effect
      fork
         wr(irp_pkg::IDX_PEND0, 8'h01);
         begin
            repeat (2) @(posedge clk_i);
            src0 <= 8'h01;
            @(posedge clk_i);
            src0 <= 8'h00;
         end
      join
      rd(irp_pkg::IDX_PEND0, 32'h01);
      serve_core(2'h3, 3'h0, 8'h00);
      rd(irp_pkg::IDX_PEND0, 32'h01);
      wr(irp_pkg::IDX_PEND0, 8'h01);
      wr(irp_pkg::IDX_SET1, 8'h3C);
      rd(irp_pkg::IDX_PEND1, 32'h3C);
      wr(irp_pkg::IDX_PEND1, 8'h3C);
      wr(irp_pkg::IDX_CTRL, 8'h00);
      $display("core test done");
      @(posedge clk_i);
      pins <= 8'h08;
      wait_n(2);
      chk(32'(p1), 32'h08);
      wr(irp_pkg::IDX_PEND1, 8'h08);
      @(posedge clk_i);
      pins <= 8'h00;
      wait_n(2);
      chk(32'(p1), 32'h08);
      wr(irp_pkg::IDX_PEND1, 8'h08);
      wr(irp_pkg::IDX_CTRL, 8'h06);
      @(posedge clk_i);
      pins <= 8'h81;
      cmp <= 1'b1;
      wait_n(2);
      chk(32'(p1), 32'h80);
      @(posedge clk_i);
      dbg <= 1'b1;
      wait_n(2);
      chk(32'(p1), 32'h81);
      $display("port test done");
      tally_and_finish();
   end
endmodule : testbench
